// ### shared/tpw_pkg.sv
package tpw_pkg;

  // ************************************************************
  // Register map: word indices, the byte address is four times each.
  // ************************************************************
  localparam logic [7:0] IDX_MODE   = 8'hA0;
  localparam logic [7:0] IDX_COUNT  = 8'hA1;
  localparam logic [7:0] IDX_RELOAD = 8'hA2;
  localparam logic [7:0] IDX_DUTY   = 8'hA3;
  localparam logic [7:0] IDX_AUX    = 8'hA4;
  localparam int         AW         = 10;
  localparam logic [AW-1:0] ADDR_MODE   = {IDX_MODE, 2'h0};
  localparam logic [AW-1:0] ADDR_COUNT  = {IDX_COUNT, 2'h0};
  localparam logic [AW-1:0] ADDR_RELOAD = {IDX_RELOAD, 2'h0};
  localparam logic [AW-1:0] ADDR_DUTY   = {IDX_DUTY, 2'h0};
  localparam logic [AW-1:0] ADDR_AUX    = {IDX_AUX, 2'h0};

  // ************************************************************
  // Field positions.
  // ************************************************************
  localparam int MODE_EN_BIT    = 7;
  localparam int MODE_RATE_HI   = 6;
  localparam int MODE_RATE_LO   = 4;
  localparam int MODE_SP_BIT    = 1;
  localparam int MODE_PE_BIT    = 0;
  localparam logic [7:0] MODE_WMASK = 8'hF3;
  localparam int AUX_CHSEL_HI   = 1;
  localparam int AUX_CHSEL_LO   = 0;
  localparam int AUX_CLKSEL_BIT = 2;
  localparam int AUX_FLAG_BIT   = 7;

  // ************************************************************
  // Reset values and counter constants.
  // ************************************************************
  localparam logic [7:0] MODE_RST   = 8'h00;
  localparam logic [7:0] COUNT_RST  = 8'h00;
  localparam logic [7:0] RELOAD_RST = 8'h00;
  localparam logic [7:0] DUTY_RST   = 8'h00;
  localparam logic [7:0] COUNT_FULL = 8'hFF;
  localparam logic [6:0] PRE_RST    = 7'h00;
  localparam logic [6:0] PRE_FULL   = 7'h7F;

endpackage

// ### verification/tpw_load.sv
module tpw_load (
  input  wire logic [1:0] pin_out,  // Level driven by the timer pins
  input  wire logic [1:0] pin_oe_n, // Output enable, low drives
  output logic      [1:0] level     // Level seen by the load
);
  timeunit 1ns;
  timeprecision 100ps;

  // A released pin is pulled down by the load, so a stale value never survives.
  always_comb level = ~pin_oe_n & pin_out;
endmodule

// ### verification/tpw_timer_tb_top.sv
module tpw_timer_tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  logic                   clk_sys, rstn, reg_wr, reg_rd, osc_high_en, osc_low_en;
  logic [tpw_pkg::AW-1:0] reg_addr;
  logic [7:0]             reg_wdata, reg_rdata;
  logic [1:0]             gpio_out, gpio_oe_n, pin_out, pin_oe_n, level;
  logic [12:0]            pwm_exp;
  int                     errors, n_compared;

  tpw_timer #(.CH(2)) i_tpw_timer (.clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .osc_high_en(osc_high_en), .osc_low_en(osc_low_en), .gpio_out(gpio_out),
    .gpio_oe_n(gpio_oe_n), .pin_out(pin_out), .pin_oe_n(pin_oe_n));
  tpw_load i_tpw_load (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .level(level));

  // ************************************************************
  // Bus and stimulus tasks.
  // ************************************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [9:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask

  // Each source tick is one cycle high followed by one cycle low.
  task automatic tk(input int n, input bit lo);
    repeat (n) begin
      @(posedge clk_sys);
      if (lo) osc_low_en <= 1'b1;
      else osc_high_en <= 1'b1;
      @(posedge clk_sys);
      osc_high_en <= 1'b0;
      osc_low_en  <= 1'b0;
    end
  endtask

  task automatic pins(input logic [3:0] exp);
    repeat (2) @(posedge clk_sys);
    #1;
    chk({4'h0, pin_oe_n, level}, {4'h0, exp});
  endtask

  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  initial begin
    #100us;
    errors++;
    stop_test();
  end

  // ************************************************************
  // Test sequence.
  // ************************************************************
  initial begin
    {rstn, reg_wr, reg_rd, osc_high_en, osc_low_en} = 5'h00;
    reg_addr  = 10'h000;
    reg_wdata = 8'h00;
    gpio_out  = 2'h2;
    gpio_oe_n = 2'h1;
    pwm_exp   = 13'h03B9;
    errors    = 0;
    n_compared = 0;
    repeat (3) @(posedge clk_sys);
    rstn <= 1'b1;
    pins(4'h6);
    for (int i = 0; i < 5; i++) rd(tpw_pkg::ADDR_MODE + 10'(4 * i), 8'h00);
    rd(10'h3FC, 8'h00);
    wr(tpw_pkg::ADDR_MODE, 8'h0C);
    rd(tpw_pkg::ADDR_MODE, 8'h00);
    wr(tpw_pkg::ADDR_MODE, 8'h72);
    rd(tpw_pkg::ADDR_MODE, 8'h72);
    wr(tpw_pkg::ADDR_RELOAD, 8'h55);
    rd(tpw_pkg::ADDR_RELOAD, 8'h00);
    $display("test registers done");
    for (int r = 0; r < 8; r++) begin
      wr(tpw_pkg::ADDR_COUNT, 8'h00);
      wr(tpw_pkg::ADDR_MODE, {1'b1, 3'(r), 4'h0});
      tk(2 * (128 >> r) - 1, 1'b0);
      wr(tpw_pkg::ADDR_MODE, 8'h00);
      rd(tpw_pkg::ADDR_COUNT, 8'h01);
    end
    wr(tpw_pkg::ADDR_AUX, 8'h04);
    wr(tpw_pkg::ADDR_COUNT, 8'h00);
    wr(tpw_pkg::ADDR_MODE, 8'hF0);
    tk(3, 1'b0);
    tk(2, 1'b1);
    wr(tpw_pkg::ADDR_MODE, 8'h00);
    rd(tpw_pkg::ADDR_COUNT, 8'h02);
    $display("test prescaler done");
    wr(tpw_pkg::ADDR_AUX, 8'h00);
    wr(tpw_pkg::ADDR_COUNT, 8'hFE);
    wr(tpw_pkg::ADDR_RELOAD, 8'hFE);
    wr(tpw_pkg::ADDR_MODE, 8'hF0);
    tk(1, 1'b0);
    wr(tpw_pkg::ADDR_RELOAD, 8'h80);
    rd(tpw_pkg::ADDR_AUX, 8'h00);
    tk(1, 1'b0);
    wr(tpw_pkg::ADDR_MODE, 8'h00);
    rd(tpw_pkg::ADDR_COUNT, 8'h80);
    rd(tpw_pkg::ADDR_AUX, 8'h80);
    wr(tpw_pkg::ADDR_AUX, 8'h80);
    rd(tpw_pkg::ADDR_AUX, 8'h80);
    wr(tpw_pkg::ADDR_AUX, 8'h00);
    rd(tpw_pkg::ADDR_AUX, 8'h00);
    $display("test overflow done");
    wr(tpw_pkg::ADDR_AUX, 8'h01);
    wr(tpw_pkg::ADDR_COUNT, 8'hFC);
    wr(tpw_pkg::ADDR_RELOAD, 8'hFC);
    wr(tpw_pkg::ADDR_DUTY, 8'hFE);
    wr(tpw_pkg::ADDR_MODE, 8'h71);
    pins(4'h6);
    wr(tpw_pkg::ADDR_MODE, 8'hF1);
    for (int i = 0; i < 13; i++) begin
      tk(1, 1'b0);
      pins({3'b001, pwm_exp[i]});
      if (i == 0) wr(tpw_pkg::ADDR_DUTY, 8'hFF);
      if (i == 7) wr(tpw_pkg::ADDR_DUTY, 8'h10);
    end
    @(posedge clk_sys);
    gpio_out  <= 2'h1;
    gpio_oe_n <= 2'h0;
    wr(tpw_pkg::ADDR_MODE, 8'h71);
    pins(4'h1);
    @(posedge clk_sys);
    gpio_out  <= 2'h2;
    gpio_oe_n <= 2'h1;
    $display("test pwm done");
    wr(tpw_pkg::ADDR_AUX, 8'h03);
    wr(tpw_pkg::ADDR_COUNT, 8'hFC);
    wr(tpw_pkg::ADDR_DUTY, 8'hFE);
    wr(tpw_pkg::ADDR_MODE, 8'h73);
    wr(tpw_pkg::ADDR_MODE, 8'hF3);
    tk(1, 1'b0);
    pins(4'h3);
    tk(1, 1'b0);
    pins(4'h0);
    tk(2, 1'b0);
    pins(4'h6);
    rd(tpw_pkg::ADDR_MODE, 8'hF2);
    $display("test single pulse done");
    @(posedge clk_sys);
    rstn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    chk({4'h0, pin_oe_n, level}, 8'h0C);
    chk(reg_rdata, 8'h00);
    @(posedge clk_sys);
    rstn <= 1'b1;
    rd(tpw_pkg::ADDR_MODE, 8'h00);
    rd(tpw_pkg::ADDR_AUX, 8'h00);
    pins(4'h6);
    $display("test reset done");
    stop_test();
  end
endmodule

// ### verilog/tpw_timer.sv
// Overview of operation
// - Mode bit 7 starts the counter when one, stops it when zero.
// - Mode bits 6:4 divide the chosen oscillator by 128 (000) down to 1 (111).
// - Mode bit 1 enables the single pulse function.
// - Mode bit 0 routes PWM to selected pins; cleared, pins stay GPIO.
// - Counter overflow sets the overflow flag until software clears it.
// - Each overflow reloads the count from the reload register automatically.
// - Reload writes wait in a first buffer until the next overflow.
// - Each PWM period is high first, then low.
// - Count equal to duty ends the high phase, output goes low.
// - Wrap from FF to the reload value ends the period and drives output high.
// - Period or duty changes while running apply from the next period.
// - Clearing either enable returns pins to their GPIO state.
// - Pins switch to PWM within one source period plus prescaler periods.
// - Each pin carries PWM only when its channel select bit is set.
// - Single pulse end clears PWM enable and returns pins to GPIO.
// - Duty not above reload keeps the PWM output low.
//
// Our own choice: the address-and-strobe port.
module tpw_timer #(
  parameter int CH = 2
) (
  input  wire logic                  clk_sys,     // System clock, 250 MHz
  input  wire logic                  rstn,        // Asynchronous reset, active low
  input  wire logic [tpw_pkg::AW-1:0] reg_addr,   // Register byte address
  input  wire logic [7:0]            reg_wdata,   // Register write data
  input  wire logic                  reg_wr,      // Write strobe
  input  wire logic                  reg_rd,      // Read strobe
  output logic      [7:0]            reg_rdata,   // Read data, cycle after strobe
  input  wire logic                  osc_high_en, // High-speed oscillator tick
  input  wire logic                  osc_low_en,  // Low-speed oscillator tick
  input  wire logic [CH-1:0]         gpio_out,    // GPIO output level per pin
  input  wire logic [CH-1:0]         gpio_oe_n,   // GPIO output enable per pin, low drives
  output logic      [CH-1:0]         pin_out,     // Pin output level
  output logic      [CH-1:0]         pin_oe_n     // Pin output enable, low drives
);

  // ************************************************************
  // Register state.
  // ************************************************************
  logic [7:0]    mode_reg;
  logic [7:0]    mode_next;
  logic [7:0]    count_reg;
  logic [7:0]    count_next;
  logic [7:0]    reload_buf_reg;
  logic [7:0]    reload_buf_next;
  logic [7:0]    reload_act_reg;
  logic [7:0]    reload_act_next;
  logic [7:0]    duty_reg;
  logic [7:0]    duty_next;
  logic [7:0]    duty_act_reg;
  logic [7:0]    duty_act_next;
  logic [CH-1:0] chsel_reg;
  logic [CH-1:0] chsel_next;
  logic          clksel_reg;
  logic          clksel_next;
  logic          flag_reg;
  logic          flag_next;
  logic [6:0]    pre_reg;
  logic [6:0]    pre_next;
  logic          active_reg;
  logic          active_next;
  logic          level_reg;
  logic          level_next;
  logic [7:0]    rdata_reg;
  logic [7:0]    rdata_next;
  logic [CH-1:0] pin_out_reg;
  logic [CH-1:0] pin_out_next;
  logic [CH-1:0] pin_oe_n_reg;
  logic [CH-1:0] pin_oe_n_next;

  // ************************************************************
  // Address decode.
  // ************************************************************
  wire wr_mode   = reg_wr && (reg_addr == tpw_pkg::ADDR_MODE);
  wire wr_count  = reg_wr && (reg_addr == tpw_pkg::ADDR_COUNT);
  wire wr_reload = reg_wr && (reg_addr == tpw_pkg::ADDR_RELOAD);
  wire wr_duty   = reg_wr && (reg_addr == tpw_pkg::ADDR_DUTY);
  wire wr_aux    = reg_wr && (reg_addr == tpw_pkg::ADDR_AUX);

  wire       cnt_en  = mode_reg[tpw_pkg::MODE_EN_BIT];
  wire [2:0] rate    = mode_reg[tpw_pkg::MODE_RATE_HI:tpw_pkg::MODE_RATE_LO];
  wire       sp_en   = mode_reg[tpw_pkg::MODE_SP_BIT];
  wire       pwm_en  = mode_reg[tpw_pkg::MODE_PE_BIT];

  // ************************************************************
  // Prescaler and counter.
  // ************************************************************
  // The prescaler restarts on every stop so that the first tick after
  // an enable always comes a full division later, never early.
  wire       src_en   = clksel_reg ? osc_low_en : osc_high_en;
  wire [6:0] pre_mask = tpw_pkg::PRE_FULL >> rate;
  wire       tick     = cnt_en && src_en && ((pre_reg & pre_mask) == pre_mask);
  wire       ovf      = tick && (count_reg == tpw_pkg::COUNT_FULL);

  assign pre_next = !cnt_en ? tpw_pkg::PRE_RST :
                    src_en  ? 7'(pre_reg + 7'h01) : pre_reg;

  // A software count write wins over the counter's own step.
  assign count_next = wr_count ? reg_wdata :
                      ovf      ? reload_buf_reg :
                      tick     ? 8'(count_reg + 8'h01) : count_reg;

  assign reload_buf_next = wr_reload ? reg_wdata : reload_buf_reg;
  // While stopped the active copy follows the buffer, so setup needs no overflow.
  assign reload_act_next = (ovf || !cnt_en) ? reload_buf_next : reload_act_reg;

  assign duty_next     = wr_duty ? reg_wdata : duty_reg;
  assign duty_act_next = (ovf || !active_reg) ? duty_next : duty_act_reg;

  // ************************************************************
  // Mode and auxiliary control.
  // ************************************************************
  wire one_done = ovf && sp_en && active_reg;

  // A software mode write in the same cycle wins over the automatic clear.
  assign mode_next = wr_mode  ? (reg_wdata & tpw_pkg::MODE_WMASK) :
                     one_done ? (mode_reg & ~(8'h01 << tpw_pkg::MODE_PE_BIT)) :
                     mode_reg;

  assign chsel_next  = wr_aux ? reg_wdata[tpw_pkg::AUX_CHSEL_HI:tpw_pkg::AUX_CHSEL_LO] : chsel_reg;
  assign clksel_next = wr_aux ? reg_wdata[tpw_pkg::AUX_CLKSEL_BIT] : clksel_reg;

  // Set wins over a clear in the same cycle; writing zero clears the flag.
  assign flag_next = ovf ? 1'b1 :
                     (wr_aux && !reg_wdata[tpw_pkg::AUX_FLAG_BIT]) ? 1'b0 : flag_reg;

  // ************************************************************
  // PWM generator.
  // ************************************************************
  // Output takes over at the first prescaled tick after both enables,
  // which bounds the hand-over delay by one division of the source.
  wire pwm_req = cnt_en && pwm_en;
  assign active_next = pwm_req && !one_done && (active_reg || tick);

  wire start    = active_next && !active_reg;
  wire duty_hit = tick && (count_next == duty_act_next);

  assign level_next = !active_next    ? 1'b0 :
                      (start || ovf)  ? (duty_act_next > count_next) :
                      duty_hit        ? 1'b0 :
                      level_reg;

  genvar gi;
  generate
    for (gi = 0; gi < CH; gi++) begin : g_pin
      wire route = active_next && chsel_reg[gi];
      assign pin_out_next[gi]  = route ? level_next : gpio_out[gi];
      assign pin_oe_n_next[gi] = route ? 1'b0 : gpio_oe_n[gi];
    end
  endgenerate

  // ************************************************************
  // Read path.
  // ************************************************************
  wire [7:0] aux_view = {flag_reg, 4'h0, clksel_reg, chsel_reg};
  wire [7:0] rd_mux   = (reg_addr == tpw_pkg::ADDR_MODE)  ? mode_reg :
                        (reg_addr == tpw_pkg::ADDR_COUNT) ? count_reg :
                        (reg_addr == tpw_pkg::ADDR_DUTY)  ? duty_reg :
                        (reg_addr == tpw_pkg::ADDR_AUX)   ? aux_view : 8'h00;
  assign rdata_next = reg_rd ? rd_mux : 8'h00;

  // ************************************************************
  // Flip-flops.
  // ************************************************************
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      mode_reg       <= tpw_pkg::MODE_RST;
      count_reg      <= tpw_pkg::COUNT_RST;
      reload_buf_reg <= tpw_pkg::RELOAD_RST;
      reload_act_reg <= tpw_pkg::RELOAD_RST;
      duty_reg       <= tpw_pkg::DUTY_RST;
      duty_act_reg   <= tpw_pkg::DUTY_RST;
    end else begin
      mode_reg       <= mode_next;
      count_reg      <= count_next;
      reload_buf_reg <= reload_buf_next;
      reload_act_reg <= reload_act_next;
      duty_reg       <= duty_next;
      duty_act_reg   <= duty_act_next;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      chsel_reg    <= '0;
      clksel_reg   <= 1'b0;
      flag_reg     <= 1'b0;
      pre_reg      <= tpw_pkg::PRE_RST;
      active_reg   <= 1'b0;
      level_reg    <= 1'b0;
      rdata_reg    <= 8'h00;
      pin_out_reg  <= '0;
      pin_oe_n_reg <= '1;
    end else begin
      chsel_reg    <= chsel_next;
      clksel_reg   <= clksel_next;
      flag_reg     <= flag_next;
      pre_reg      <= pre_next;
      active_reg   <= active_next;
      level_reg    <= level_next;
      rdata_reg    <= rdata_next;
      pin_out_reg  <= pin_out_next;
      pin_oe_n_reg <= pin_oe_n_next;
    end
  end

  assign reg_rdata = rdata_reg;
  assign pin_out   = pin_out_reg;
  assign pin_oe_n  = pin_oe_n_reg;

  // ************************************************************
  // Assertions.
  // ************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  AST_STOP_HOLDS:
    assert property (!cnt_en && !wr_count |=> $stable(count_reg))
      else $error("Stopped counter changed value.");

  AST_STEP_ONE:
    assert property (tick && !ovf && !wr_count |=> count_reg == 8'($past(count_reg) + 8'h01))
      else $error("Counter did not step by one.");

  AST_RELOAD_ON_WRAP:
    assert property (ovf && !wr_count |=> count_reg == $past(reload_buf_reg))
      else $error("Count not reloaded at overflow.");

  AST_FLAG_STICKY:
    assert property (ovf |=> flag_reg ##1 (flag_reg || $past(wr_aux)))
      else $error("Overflow flag not set or lost.");

  AST_BUFFER_WAITS:
    assert property (cnt_en && !ovf ##1 cnt_en |-> $stable(reload_act_reg))
      else $error("Active reload changed between overflows.");

  AST_GPIO_RETURN:
    assert property (!pwm_req |=> pin_out == $past(gpio_out) && pin_oe_n == $past(gpio_oe_n))
      else $error("Pins not returned to GPIO.");

  AST_LOW_AT_MATCH:
    assert property (duty_hit && !ovf && !start |=> !level_reg)
      else $error("Output not low at duty match.");

  AST_HIGH_AT_WRAP:
    assert property (ovf && active_next && (duty_act_next > count_next) |=> level_reg)
      else $error("Output not high at period start.");

  AST_LOW_DUTY_SMALL:
    assert property (ovf && (duty_act_next <= count_next) |=> !level_reg)
      else $error("Output high with duty not above reload.");

  AST_ONE_SHOT_ENDS:
    assert property (one_done && !wr_mode |=> !pwm_en && !active_reg)
      else $error("Single pulse did not end.");

  AST_SYNC_ON_TICK:
    assert property ($rose(active_reg) |-> $past(tick))
      else $error("PWM took pins without a prescaled tick.");

  AST_RESERVED_ZERO:
    assert property (mode_reg[3:2] == 2'b00)
      else $error("Reserved mode bits not zero.");

  AST_MODE_WRITE:
    assert property (wr_mode |=> mode_reg == ($past(reg_wdata) & tpw_pkg::MODE_WMASK))
      else $error("Mode write did not land.");

  AST_PRESCALE_STEP:
    assert property (cnt_en && src_en |=> pre_reg == 7'($past(pre_reg) + 7'h01))
      else $error("Prescaler did not count a source tick.");

  AST_PRESCALE_RESTART:
    assert property (!cnt_en |=> pre_reg == tpw_pkg::PRE_RST)
      else $error("Prescaler not restarted while stopped.");

  AST_FLAG_HOLDS:
    assert property (flag_reg && !wr_aux |=> flag_reg)
      else $error("Overflow flag dropped without a clear.");

  AST_DUTY_HOLDS:
    assert property (active_reg && !ovf |=> $stable(duty_act_reg))
      else $error("Active duty changed inside a period.");

  AST_HIGH_FIRST:
    assert property (start && (duty_act_next > count_next) |=> level_reg)
      else $error("Period did not open with the high phase.");

  AST_PWM_OFF_IDLE:
    assert property (!pwm_en |=> !active_reg)
      else $error("PWM active with output enable cleared.");

  AST_ROUTED_PIN:
    assert property (active_next && chsel_reg[0] |=> !pin_oe_n[0] && pin_out[0] == level_reg)
      else $error("Selected pin does not carry PWM.");

  AST_UNROUTED_PIN:
    assert property (!chsel_reg[CH-1] |=> pin_out[CH-1] == $past(gpio_out[CH-1])
                     && pin_oe_n[CH-1] == $past(gpio_oe_n[CH-1]))
      else $error("Unselected pin left GPIO control.");

endmodule
